// ==== dual_byte_port_bus_share.sv ====
// Purpose: Two byte-wide ports shared with the external data bus
// Assumes: Mode pins and standby levels come from same-clock logic
// Notes: Bus-side data and enables come from the bus controller
`default_nettype none
module dual_byte_port_bus_share (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [2:0] opMode,
    input wire logic hwStandby,
    input wire logic swStandby,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic [7:0] busOutData,
    input wire logic busDrive,
    output logic [15:0] busInData,
    input wire logic [7:0] firstPinIn,
    output logic [7:0] firstPinOut,
    output logic [7:0] firstPinOe,
    input wire logic [7:0] secondPinIn,
    output logic [7:0] secondPinOut,
    output logic [7:0] secondPinOe,
    output logic [7:0] secondPullupOn,
    output logic wideBusMode
);
    logic [7:0] firstDir;
    logic [7:0] secondDir;
    logic [7:0] firstLatch;
    logic [7:0] secondLatch;
    logic [7:0] pullEnable;
    logic [7:0] areaWidth;
    logic [7:0] firstSync;
    logic [7:0] secondSync;
    logic singleChip;
    logic expanded;
    logic wideBus;
    logic secondIsIo;
    logic [7:0] rdData_reg;
    logic [7:0] rdData_next;
    logic [7:0] firstOut_reg;
    logic [7:0] firstOut_next;
    logic [7:0] firstOe_reg;
    logic [7:0] firstOe_next;
    logic [7:0] secondOut_reg;
    logic [7:0] secondOut_next;
    logic [7:0] secondOe_reg;
    logic [7:0] secondOe_next;
    logic [7:0] pull_reg;
    logic [7:0] pull_next;
    logic wide_reg;
    logic wide_next;
    logic [15:0] busIn_reg;
    logic [15:0] busIn_next;

    function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] latch,
                                             input logic [7:0] pin);
        port_read = (dir & latch) | (~dir & pin);
    endfunction

    function automatic logic hit(input logic [15:0] addr, input logic [15:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Registers; hardware standby loads reset values, software standby is not seen at all
    port_reg_byte #(
        .RESET_VALUE(dual_port_pkg::REG_RESET)
    ) firstDirReg (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .hwStandby(hwStandby),
        .writeEn(regWrite && hit(regAddr, dual_port_pkg::FIRST_DIR_OFS)),
        .writeData(regWrData),
        .value(firstDir)
    );
    port_reg_byte #(
        .RESET_VALUE(dual_port_pkg::REG_RESET)
    ) secondDirReg (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .hwStandby(hwStandby),
        .writeEn(regWrite && hit(regAddr, dual_port_pkg::SECOND_DIR_OFS)),
        .writeData(regWrData),
        .value(secondDir)
    );
    port_reg_byte #(
        .RESET_VALUE(dual_port_pkg::REG_RESET)
    ) firstLatchReg (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .hwStandby(hwStandby),
        .writeEn(regWrite && hit(regAddr, dual_port_pkg::FIRST_LATCH_OFS)),
        .writeData(regWrData),
        .value(firstLatch)
    );
    port_reg_byte #(
        .RESET_VALUE(dual_port_pkg::REG_RESET)
    ) secondLatchReg (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .hwStandby(hwStandby),
        .writeEn(regWrite && hit(regAddr, dual_port_pkg::SECOND_LATCH_OFS)),
        .writeData(regWrData),
        .value(secondLatch)
    );
    port_reg_byte #(
        .RESET_VALUE(dual_port_pkg::REG_RESET)
    ) pullEnReg (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .hwStandby(hwStandby),
        .writeEn(regWrite && hit(regAddr, dual_port_pkg::SECOND_PULLUP_OFS)),
        .writeData(regWrData),
        .value(pullEnable)
    );
    port_reg_byte #(
        .RESET_VALUE(dual_port_pkg::AREA_WIDTH_RESET)
    ) areaWidthReg (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .hwStandby(hwStandby),
        .writeEn(regWrite && hit(regAddr, dual_port_pkg::AREA_WIDTH_OFS)),
        .writeData(regWrData),
        .value(areaWidth)
    );

    // Pins are asynchronous; a read lags a pin change by about five edges
    pin_sync #(
        .WIDTH(8)
    ) firstSyncU (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .pinIn(firstPinIn),
        .pinOut(firstSync)
    );
    pin_sync #(
        .WIDTH(8)
    ) secondSyncU (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .pinIn(secondPinIn),
        .pinOut(secondSync)
    );

    always_comb begin
        singleChip = (opMode == dual_port_pkg::SINGLE_CHIP_MODE);
        expanded = (opMode >= dual_port_pkg::FIRST_EXPANDED_MODE) &&
                   (opMode <= dual_port_pkg::LAST_EXPANDED_MODE);
        // A bit of 1 marks an 8-bit area; any 0 means a 16-bit area
        wideBus = expanded && (areaWidth != dual_port_pkg::ALL_AREAS_8BIT);
        secondIsIo = singleChip || (expanded && !wideBus);
    end

    always_comb begin
        rdData_next = dual_port_pkg::UNMAPPED_READ;
        if (regRead) begin
            case (regAddr)
                dual_port_pkg::FIRST_DIR_OFS: rdData_next = dual_port_pkg::WO_READ_VALUE;
                dual_port_pkg::SECOND_DIR_OFS: rdData_next = dual_port_pkg::WO_READ_VALUE;
                dual_port_pkg::FIRST_LATCH_OFS: rdData_next = port_read(firstDir, firstLatch,
                                                                        firstSync);
                dual_port_pkg::SECOND_LATCH_OFS: rdData_next = port_read(secondDir,
                                                                         secondLatch,
                                                                         secondSync);
                dual_port_pkg::SECOND_PULLUP_OFS: rdData_next = pullEnable;
                dual_port_pkg::AREA_WIDTH_OFS: rdData_next = areaWidth;
                default: rdData_next = dual_port_pkg::UNMAPPED_READ;
            endcase
        end
    end

    always_comb begin
        firstOut_next = '0;
        firstOe_next = '0;
        secondOut_next = '0;
        secondOe_next = '0;
        pull_next = '0;
        // Software standby only gates the bus drive enables; latches and directions hold
        if (singleChip) begin
            firstOut_next = firstLatch;
            firstOe_next = firstDir;
        end else if (expanded) begin
            firstOut_next = busOutData;
            firstOe_next = (busDrive && !swStandby) ? 8'hff : 8'h00;
        end
        if (secondIsIo) begin
            secondOut_next = secondLatch;
            secondOe_next = secondDir;
            pull_next = ~secondDir & pullEnable;
        end else if (wideBus) begin
            secondOut_next = busOutData;
            secondOe_next = (busDrive && !swStandby) ? 8'hff : 8'h00;
        end
        if (hwStandby) begin
            firstOe_next = '0;
            secondOe_next = '0;
            pull_next = '0;
        end
        wide_next = wideBus;
        busIn_next = {secondSync, firstSync};
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdData_reg <= '0;
            firstOut_reg <= '0;
            firstOe_reg <= '0;
            secondOut_reg <= '0;
            secondOe_reg <= '0;
            pull_reg <= '0;
            wide_reg <= 1'b0;
            busIn_reg <= '0;
        end else begin
            rdData_reg <= rdData_next;
            firstOut_reg <= firstOut_next;
            firstOe_reg <= firstOe_next;
            secondOut_reg <= secondOut_next;
            secondOe_reg <= secondOe_next;
            pull_reg <= pull_next;
            wide_reg <= wide_next;
            busIn_reg <= busIn_next;
        end
    end

    assign regRdData = rdData_reg;
    assign firstPinOut = firstOut_reg;
    assign firstPinOe = firstOe_reg;
    assign secondPinOut = secondOut_reg;
    assign secondPinOe = secondOe_reg;
    assign secondPullupOn = pull_reg;
    assign wideBusMode = wide_reg;
    assign busInData = busIn_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    first_io_drive_a: assert property (singleChip && !hwStandby |=>
        firstPinOe == $past(firstDir) && firstPinOut == $past(firstLatch))
        else $error("first port drive mismatch in single-chip mode");
    first_bus_ignore_a: assert property (expanded && !busDrive |=> firstPinOe == 8'h00)
        else $error("first port direction acted in expanded mode");
    dir_read_ones_a: assert property (regRead && (regAddr == dual_port_pkg::FIRST_DIR_OFS ||
        regAddr == dual_port_pkg::SECOND_DIR_OFS) |=> regRdData == 8'hff)
        else $error("direction read not all ones");
    hw_standby_clear_a: assert property (hwStandby |=> firstDir == 8'h00 &&
        firstLatch == 8'h00) else $error("first port not cleared in hardware standby");
    second_clear_a: assert property (hwStandby |=> secondDir == 8'h00 &&
        secondLatch == 8'h00 && pullEnable == 8'h00) else $error("second port not cleared");
    sw_standby_hold_a: assert property (swStandby && !hwStandby && !regWrite |=>
        $stable(firstLatch) && $stable(secondDir)) else $error("standby lost contents");
    latch_write_a: assert property (regWrite && !hwStandby &&
        regAddr == dual_port_pkg::FIRST_LATCH_OFS |=> firstLatch == $past(regWrData))
        else $error("latch write lost");
    data_read_mix_a: assert property (regRead &&
        regAddr == dual_port_pkg::SECOND_LATCH_OFS |=> regRdData ==
        (($past(secondDir) & $past(secondLatch)) | (~$past(secondDir) & $past(secondSync))))
        else $error("data read mixes wrongly");
    wide_bus_mode_a: assert property (expanded && areaWidth != 8'hff |=> wideBusMode)
        else $error("16-bit bus mode not entered");
    pullup_gate_a: assert property (##1 (secondPullupOn != 8'h00) |->
        $past(secondIsIo) && !$past(hwStandby) && (secondPullupOn & $past(secondDir)) == 8'h00)
        else $error("pull-up on when it should be off");
    second_io_drive_a: assert property (secondIsIo && !hwStandby |=>
        secondPinOe == $past(secondDir) && secondPinOut == $past(secondLatch))
        else $error("second port drive mismatch in I/O use");
    second_bus_drive_a: assert property (wideBus && busDrive && !swStandby &&
        !hwStandby |=> secondPinOe == 8'hff && secondPinOut == $past(busOutData))
        else $error("second port not driving the upper data bus");
    width_hold_a: assert property (!hwStandby && !(regWrite &&
        regAddr == dual_port_pkg::AREA_WIDTH_OFS) |=> $stable(areaWidth))
        else $error("area widths changed without a write");
    standby_off_a: assert property (hwStandby |=> secondPullupOn == 8'h00 &&
        firstPinOe == 8'h00 && secondPinOe == 8'h00) else $error("enables not off in standby");
    pull_write_a: assert property (regWrite && !hwStandby &&
        regAddr == dual_port_pkg::SECOND_PULLUP_OFS |=> pullEnable == $past(regWrData))
        else $error("pull-up enable write lost");
    width_follow_a: assert property (regWrite && !hwStandby && regWrData != 8'hff &&
        regAddr == dual_port_pkg::AREA_WIDTH_OFS ##1 expanded |=> wideBusMode)
        else $error("bus mode did not follow the area widths");

    io_mode_c: cover property (singleChip && firstDir != 8'h00 ##1 regRead);
    wide_mode_c: cover property (expanded && wideBus ##1 busDrive);
    narrow_pull_c: cover property (expanded && !wideBus && secondPullupOn != 8'h00);
    standby_c: cover property (swStandby && secondPinOe != 8'h00);
    word_drive_c: cover property (wideBus && busDrive ##1 secondPinOe == 8'hff);
endmodule
`default_nettype wire

// ==== dual_port_pkg.sv ====
// Purpose: Shared constants for the dual byte port block
// Assumes: Register offsets are the low 16 bits of the address
// Notes: Mode codes follow the operating mode pins
`default_nettype none
package dual_port_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [15:0] FIRST_DIR_OFS = 16'hffc4;
    localparam logic [15:0] SECOND_DIR_OFS = 16'hffc5;
    localparam logic [15:0] FIRST_LATCH_OFS = 16'hffc6;
    localparam logic [15:0] SECOND_LATCH_OFS = 16'hffc7;
    localparam logic [15:0] SECOND_PULLUP_OFS = 16'hffda;
    localparam logic [15:0] AREA_WIDTH_OFS = 16'hffec;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] WO_READ_VALUE = 8'hff;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [7:0] AREA_WIDTH_RESET = 8'hff;
    localparam logic [7:0] ALL_AREAS_8BIT = 8'hff;
    localparam logic [2:0] SINGLE_CHIP_MODE = 3'h7;
    localparam logic [2:0] FIRST_EXPANDED_MODE = 3'h1;
    localparam logic [2:0] LAST_EXPANDED_MODE = 3'h6;
endpackage
`default_nettype wire

// ==== pin_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter for a pin group
// Assumes: Pins are asynchronous to sys_clk
// Notes: A change counts once stages two and three agree
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] stable_reg;
    logic [WIDTH-1:0] stable_next;

    always_comb begin
        // Only bits where the last two stages agree may move
        stable_next = (stage2_reg & stage3_reg) | (stable_reg & (stage2_reg | stage3_reg));
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
            stable_reg <= '0;
        end else begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            stable_reg <= stable_next;
        end
    end

    assign pinOut = stable_reg;
endmodule
`default_nettype wire

// ==== pin_world.sv ====
// Purpose: Pins and outside world seen by both byte ports
// Assumes: Outside drivers yield wherever the block drives
// Notes: Undriven lines without pull-up toggle, so no stale level passes
`default_nettype none
module pin_world (
    input wire logic sys_clk,
    input wire logic [7:0] firstPinOut,
    input wire logic [7:0] firstPinOe,
    input wire logic [7:0] secondPinOut,
    input wire logic [7:0] secondPinOe,
    input wire logic [7:0] secondPullupOn,
    input wire logic [7:0] extFirst,
    input wire logic [7:0] extSecond,
    input wire logic [7:0] extEn,
    output logic [7:0] firstPinIn,
    output logic [7:0] secondPinIn
);
    logic [7:0] floatReg = 8'h55;
    always @(posedge sys_clk) begin
        floatReg <= ~floatReg;
    end
    // Block drive wins, then the outside, then the pull-up
    assign firstPinIn = (firstPinOe & firstPinOut) | (~firstPinOe & extFirst);
    assign secondPinIn = (secondPinOe & secondPinOut) | (~secondPinOe & extEn & extSecond)
        | (~secondPinOe & ~extEn & (secondPullupOn | floatReg));
endmodule
`default_nettype wire

// ==== port_reg_byte.sv ====
// Purpose: One 8-bit control register with standby reset to RESET_VALUE
// Assumes: Write strobe is already address decoded
// Notes: Hardware standby loads RESET_VALUE, software standby keeps contents
`default_nettype none
module port_reg_byte #(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic hwStandby,
    input wire logic writeEn,
    input wire logic [7:0] writeData,
    output logic [7:0] value
);
    logic [7:0] value_reg;
    logic [7:0] value_next;

    always_comb begin
        value_next = value_reg;
        if (hwStandby) begin
            value_next = RESET_VALUE;
        end else if (writeEn) begin
            value_next = writeData;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            value_reg <= RESET_VALUE;
        end else begin
            value_reg <= value_next;
        end
    end

    assign value = value_reg;
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the dual byte port block
// Assumes: Pin world model closes the pin loop
// Notes: Reads are noted in a queue and checked in the cycle after the strobe
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errorCnt++; \
    $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk, arst_n, hwStandby, swStandby, regWrite, regRead, busDrive, wideBusMode;
    logic [2:0] opMode;
    logic [15:0] regAddr, busInData;
    logic [7:0] regWrData, regRdData, busOutData, firstPinIn, firstPinOut, firstPinOe;
    logic [7:0] secondPinIn, secondPinOut, secondPinOe, secondPullupOn;
    logic [7:0] extFirst, extSecond, extEn, d1, l1, d2, l2, p, e1, e2, rdExp;
    logic [7:0] expQ[$];
    logic rdSeen = 1'b0;
    int errorCnt = 0;
    int checked = 0;
    int cycles = 0;
    dual_byte_port_bus_share i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .opMode(opMode),
        .hwStandby(hwStandby), .swStandby(swStandby), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .busOutData(busOutData), .busDrive(busDrive),
        .busInData(busInData), .firstPinIn(firstPinIn), .firstPinOut(firstPinOut),
        .firstPinOe(firstPinOe), .secondPinIn(secondPinIn), .secondPinOut(secondPinOut),
        .secondPinOe(secondPinOe), .secondPullupOn(secondPullupOn),
        .wideBusMode(wideBusMode));
    pin_world i_world (.sys_clk(sys_clk), .firstPinOut(firstPinOut),
        .firstPinOe(firstPinOe), .secondPinOut(secondPinOut), .secondPinOe(secondPinOe),
        .secondPullupOn(secondPullupOn), .extFirst(extFirst), .extSecond(extSecond),
        .extEn(extEn), .firstPinIn(firstPinIn), .secondPinIn(secondPinIn));
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, errorCnt);
        if (errorCnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask
    task automatic reg_rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        regRead <= 1'b1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge sys_clk);
        regRead <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge sys_clk) begin
        rdSeen <= regRead;
        cycles++;
        if (cycles == 5000) begin
            errorCnt++;
            complete_run();
        end
    end
    always @(negedge sys_clk) begin
        if (rdSeen) begin
            rdExp = expQ.pop_front();
            `CHK(regRdData, rdExp)
        end
    end
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        arst_n = 1'b0;
        opMode = 3'h7;
        hwStandby = 1'b0;
        swStandby = 1'b0;
        regAddr = 16'h0000;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        busOutData = 8'h00;
        busDrive = 1'b0;
        extFirst = 8'h00;
        extSecond = 8'h00;
        extEn = 8'hff;
        void'($urandom(32'h0f51e3c9));
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        wait_clk(1);
        `CHK(firstPinOe, 8'h00)
        `CHK(secondPullupOn, 8'h00)
        reg_rd(16'hffda, 8'h00);
        reg_rd(16'hffec, 8'hff);
        reg_wr(16'hffc4, 8'hff);
        reg_wr(16'hffc5, 8'hff);
        reg_rd(16'hffc6, 8'h00);
        reg_rd(16'hffc7, 8'h00);
        for (int i = 0; i < 8; i++) begin
            d1 = 8'($urandom);
            l1 = 8'($urandom);
            d2 = 8'($urandom);
            l2 = 8'($urandom);
            p = 8'($urandom);
            e1 = 8'($urandom);
            e2 = 8'($urandom);
            @(posedge sys_clk);
            extFirst <= e1;
            extSecond <= e2;
            reg_wr(16'hffc4, d1);
            reg_wr(16'hffc6, l1);
            reg_wr(16'hffc5, d2);
            reg_wr(16'hffc7, l2);
            reg_wr(16'hffda, p);
            wait_clk(6);
            `CHK(firstPinOe, d1)
            `CHK(firstPinOut & d1, l1 & d1)
            `CHK(secondPinOe, d2)
            `CHK(secondPinOut & d2, l2 & d2)
            `CHK(secondPullupOn, p & ~d2)
            reg_rd(16'hffc6, (d1 & l1) | (~d1 & e1));
            reg_rd(16'hffc7, (d2 & l2) | (~d2 & e2));
            reg_rd(16'hffc4, 8'hff);
            reg_rd(16'hffc5, 8'hff);
            reg_rd(16'hffda, p);
        end
        @(posedge sys_clk);
        swStandby <= 1'b1;
        wait_clk(4);
        `CHK(firstPinOe, d1)
        `CHK(firstPinOut & d1, l1 & d1)
        `CHK(secondPinOe, d2)
        `CHK(secondPullupOn, p & ~d2)
        reg_rd(16'hffc7, (d2 & l2) | (~d2 & e2));
        @(posedge sys_clk);
        swStandby <= 1'b0;
        reg_rd(16'hffc6, (d1 & l1) | (~d1 & e1));
        @(posedge sys_clk);
        hwStandby <= 1'b1;
        reg_wr(16'hffda, 8'hff);
        wait_clk(3);
        `CHK(firstPinOe | secondPinOe, 8'h00)
        `CHK(secondPullupOn, 8'h00)
        @(posedge sys_clk);
        hwStandby <= 1'b0;
        reg_rd(16'hffda, 8'h00);
        reg_wr(16'hffc4, 8'hff);
        reg_wr(16'hffc5, 8'hff);
        reg_rd(16'hffc6, 8'h00);
        reg_rd(16'hffc7, 8'h00);
        reg_wr(16'hff00, 8'h5a);
        reg_rd(16'hff00, 8'h00);
        // Expanded mode, all areas byte wide, then one area word wide
        @(posedge sys_clk);
        opMode <= 3'h3;
        reg_wr(16'hffc5, 8'h0f);
        reg_wr(16'hffc7, 8'ha5);
        reg_wr(16'hffda, 8'hff);
        wait_clk(6);
        `CHK(firstPinOe, 8'h00)
        `CHK(wideBusMode, 1'b0)
        `CHK(secondPinOe, 8'h0f)
        `CHK(secondPullupOn, 8'hf0)
        @(posedge sys_clk);
        extEn <= 8'h00;
        busDrive <= 1'b1;
        busOutData <= e1;
        wait_clk(6);
        `CHK(firstPinOe, 8'hff)
        `CHK(firstPinOut, e1)
        reg_rd(16'hffc7, 8'hf5);
        @(posedge sys_clk);
        busDrive <= 1'b0;
        extEn <= 8'hff;
        reg_wr(16'hffec, 8'hfe);
        wait_clk(6);
        `CHK(wideBusMode, 1'b1)
        `CHK(secondPullupOn, 8'h00)
        `CHK(busInData, {e2, e1})
        @(posedge sys_clk);
        busDrive <= 1'b1;
        busOutData <= e2;
        wait_clk(3);
        `CHK(secondPinOe, 8'hff)
        `CHK(secondPinOut, e2)
        @(posedge sys_clk);
        swStandby <= 1'b1;
        wait_clk(3);
        `CHK(wideBusMode, 1'b1)
        `CHK(secondPullupOn, 8'h00)
        `CHK(secondPinOe, 8'h00)
        @(posedge sys_clk);
        swStandby <= 1'b0;
        busDrive <= 1'b0;
        reg_wr(16'hffec, 8'hff);
        wait_clk(4);
        `CHK(wideBusMode, 1'b0)
        `CHK(secondPullupOn, 8'hf0)
        @(posedge sys_clk);
        opMode <= 3'h6;
        wait_clk(3);
        `CHK(firstPinOe, 8'h00)
        `CHK(secondPullupOn, 8'hf0)
        @(posedge sys_clk);
        opMode <= 3'h0;
        wait_clk(3);
        `CHK(secondPullupOn, 8'h00)
        wait_clk(2);
        complete_run();
    end
endmodule
`default_nettype wire
